// File: rtl/sgb_device.sv
// Sound generator: bus port, register file, I/O ports, tone/noise/envelope
//
// Our own choices: the placing of the registers and register access over APB.
`default_nettype none
module sgb_device #(
	parameter logic [3:0] SELECT_NIBBLE = 4'h0
) (
	// Clock and reset
	input  wire logic       I_CLOCK,
	input  wire logic       I_RESET_N,
	// Processor bus
	sgb_if.device           bus,
	// First I/O port
	input  wire logic [7:0] i_FIRST_PORT_IN,
	input  wire logic [7:0] i_FIRST_PORT_DRIVEN,
	output logic      [7:0] o_FIRST_PORT_OUT,
	output logic      [7:0] o_FIRST_PORT_OE_N,
	// Second I/O port
	input  wire logic [7:0] i_SECOND_PORT_IN,
	input  wire logic [7:0] i_SECOND_PORT_DRIVEN,
	output logic      [7:0] o_SECOND_PORT_OUT,
	output logic      [7:0] o_SECOND_PORT_OE_N,
	// Converter levels
	output logic      [3:0] o_LEVEL_A,
	output logic      [3:0] o_LEVEL_B,
	output logic      [3:0] o_LEVEL_C
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [7:0]  regs [sgb_pkg::REG_COUNT];
	logic [3:0]  reg_num;
	logic        selected;
	logic [1:0]  code;
	logic        active;
	logic        do_write;
	logic        write_prev;
	logic        select_match;
	logic [7:0]  read_data;
	logic [7:0]  first_pins;
	logic [7:0]  second_pins;
	logic        first_out;
	logic        second_out;
	logic [7:0]  prescale;
	logic        tone_tick;
	logic        env_tick;
	logic [11:0] tone_cnt [3];
	logic [2:0]  tone;
	logic [4:0]  noise_cnt;
	logic [16:0] lfsr;
	logic [15:0] env_cnt;
	logic [3:0]  env_step;
	logic        env_inv;
	logic        env_hold;
	logic        env_restart;
	logic [3:0]  env_level;
	logic [3:0]  next_level [3];

	// Pull-up: an undriven pin reads as one
	function automatic logic [7:0] pin_level(input logic [7:0] pin, input logic [7:0] drv);
		pin_level = (pin & drv) | ~drv;
	endfunction : pin_level

	// Period register pair; zero behaves as one
	function automatic logic [11:0] tone_period(input logic [7:0] lo, input logic [7:0] hi);
		logic [11:0] p;
		p = {hi[3:0], lo};
		tone_period = (p == 12'h0) ? 12'h1 : p;
	endfunction : tone_period

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign code   = {bus.bus_direction_in, bus.bus_control_first};
	assign active = bus.bus_control_second;
	assign select_match = (bus.muxed_data_address_bus[7:4] == SELECT_NIBBLE) &&
		(bus.extra_select_high == sgb_pkg::SEL_HIGH_MATCH) &&
		(bus.extra_select_low == sgb_pkg::SEL_LOW_MATCH);
	assign do_write = active && code == sgb_pkg::BUS_WRITE && selected;
	assign env_restart = do_write && !write_prev && reg_num == sgb_pkg::REG_ENV_SHAPE;

	// Address latch, kept across data cycles
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			reg_num    <= 4'h0;
			selected   <= 1'b0;
			write_prev <= 1'b0;
		end else begin
			write_prev <= do_write;
			if (active && code == sgb_pkg::BUS_LATCH) begin
				reg_num  <= bus.muxed_data_address_bus[3:0];
				selected <= select_match;
			end
		end
	end

	// ----------------------------------------------------------------
	// Register file and port latches
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			for (int i = 0; i < sgb_pkg::REG_COUNT; i++)
				regs[i] <= sgb_pkg::REG_RESET;
		end else if (do_write) begin
			regs[reg_num] <= bus.muxed_data_address_bus;
			// Switching a port to input drops its output data
			if (reg_num == sgb_pkg::REG_ENABLE) begin
				if (!bus.muxed_data_address_bus[sgb_pkg::EN_FIRST_DIR])
					regs[sgb_pkg::REG_FIRST_PORT] <= sgb_pkg::REG_RESET;
				if (!bus.muxed_data_address_bus[sgb_pkg::EN_SECOND_DIR])
					regs[sgb_pkg::REG_SECOND_PORT] <= sgb_pkg::REG_RESET;
			end
		end
	end

	// Port direction and pins
	assign first_out          = regs[sgb_pkg::REG_ENABLE][sgb_pkg::EN_FIRST_DIR];
	assign second_out         = regs[sgb_pkg::REG_ENABLE][sgb_pkg::EN_SECOND_DIR];
	assign first_pins         = pin_level(i_FIRST_PORT_IN, i_FIRST_PORT_DRIVEN);
	assign second_pins        = pin_level(i_SECOND_PORT_IN, i_SECOND_PORT_DRIVEN);
	assign o_FIRST_PORT_OE_N  = {8{!first_out}};
	assign o_SECOND_PORT_OE_N = {8{!second_out}};

	// Port output data from the latches
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			o_FIRST_PORT_OUT  <= 8'h0;
			o_SECOND_PORT_OUT <= 8'h0;
		end else begin
			o_FIRST_PORT_OUT  <= regs[sgb_pkg::REG_FIRST_PORT];
			o_SECOND_PORT_OUT <= regs[sgb_pkg::REG_SECOND_PORT];
		end
	end

	// ----------------------------------------------------------------
	// Read path: registered, driven only for a selected read
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			read_data <= 8'h0;
		end else if (reg_num == sgb_pkg::REG_FIRST_PORT) begin
			read_data <= first_out ? regs[reg_num] : first_pins;
		end else if (reg_num == sgb_pkg::REG_SECOND_PORT) begin
			read_data <= second_out ? regs[reg_num] : second_pins;
		end else begin
			read_data <= regs[reg_num];
		end
	end

	assign bus.dev_da      = read_data;
	assign bus.dev_da_oe_n = !(active && code == sgb_pkg::BUS_READ && selected);

	// ----------------------------------------------------------------
	// Prescaler: all generator timing from the one clock
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N)
			prescale <= 8'h0;
		else
			prescale <= prescale + 8'h1;
	end

	assign tone_tick = (prescale[3:0] == sgb_pkg::PRESCALE_TONE[3:0]);
	assign env_tick  = (prescale == sgb_pkg::PRESCALE_ENV);

	// Three square-wave tone generators
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			tone <= 3'b000;
			for (int i = 0; i < 3; i++)
				tone_cnt[i] <= 12'h0;
		end else if (tone_tick) begin
			for (int i = 0; i < 3; i++) begin
				if (tone_cnt[i] + 12'h1 >= tone_period(regs[2*i], regs[2*i+1])) begin
					tone_cnt[i] <= 12'h0;
					tone[i]     <= !tone[i];
				end else begin
					tone_cnt[i] <= tone_cnt[i] + 12'h1;
				end
			end
		end
	end

	// Shared pseudo-random noise source
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			noise_cnt <= 5'h0;
			lfsr      <= sgb_pkg::NOISE_SEED;
		end else if (tone_tick) begin
			if (noise_cnt + 5'h1 >= regs[sgb_pkg::REG_NOISE][4:0]) begin
				noise_cnt <= 5'h0;
				lfsr      <= {lfsr[0] ^ lfsr[3], lfsr[16:1]};
			end else begin
				noise_cnt <= noise_cnt + 5'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Envelope generator; shape write restarts it
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			env_cnt  <= 16'h0;
			env_step <= 4'h0;
			env_inv  <= 1'b0;
			env_hold <= 1'b0;
		end else if (env_restart) begin
			env_cnt  <= 16'h0;
			env_step <= 4'h0;
			env_inv  <= bus.muxed_data_address_bus[sgb_pkg::SHAPE_ATTACK];
			env_hold <= 1'b0;
		end else if (env_tick && !env_hold) begin
			if (env_cnt + 16'h1 >= {regs[sgb_pkg::REG_ENV_COARSE], regs[sgb_pkg::REG_ENV_FINE]}) begin
				env_cnt <= 16'h0;
				if (env_step != 4'hf) begin
					env_step <= env_step + 4'h1;
				end else if (!regs[sgb_pkg::REG_ENV_SHAPE][sgb_pkg::SHAPE_CONT]) begin
					env_hold <= 1'b1; // Single sweep ends at zero
					env_inv  <= 1'b0;
				end else if (regs[sgb_pkg::REG_ENV_SHAPE][sgb_pkg::SHAPE_HOLD]) begin
					env_hold <= 1'b1;
					env_inv  <= env_inv ^ regs[sgb_pkg::REG_ENV_SHAPE][sgb_pkg::SHAPE_ALT];
				end else begin
					env_step <= 4'h0;
					env_inv  <= env_inv ^ regs[sgb_pkg::REG_ENV_SHAPE][sgb_pkg::SHAPE_ALT];
				end
			end else begin
				env_cnt <= env_cnt + 16'h1;
			end
		end
	end

	assign env_level = env_inv ? env_step : ~env_step;

	// ----------------------------------------------------------------
	// Mixers and amplitude control to the converters
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_level[i] = regs[sgb_pkg::REG_AMP_A + 4'(i)][sgb_pkg::AMP_ENV_BIT] ?
				env_level : regs[sgb_pkg::REG_AMP_A + 4'(i)][3:0];
			if (!((tone[i] | regs[sgb_pkg::REG_ENABLE][i]) &
				(lfsr[0] | regs[sgb_pkg::REG_ENABLE][sgb_pkg::EN_NOISE_LSB + i])))
				next_level[i] = 4'h0;
		end
	end

	// Converter levels registered
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			o_LEVEL_A <= 4'h0;
			o_LEVEL_B <= 4'h0;
			o_LEVEL_C <= 4'h0;
		end else begin
			o_LEVEL_A <= next_level[0];
			o_LEVEL_B <= next_level[1];
			o_LEVEL_C <= next_level[2];
		end
	end

endmodule : sgb_device
`default_nettype wire

// File: rtl/sgb_pkg.sv
// Shared constants for the sound generator bus port and its host controller
`default_nettype none
package sgb_pkg;

	// ----------------------------------------------------------------
	// Device register numbers and fields
	// ----------------------------------------------------------------
	localparam int         REG_COUNT        = 16;
	localparam logic [3:0] REG_NOISE        = 4'h6;
	localparam logic [3:0] REG_ENABLE       = 4'h7;
	localparam logic [3:0] REG_AMP_A        = 4'h8;
	localparam logic [3:0] REG_ENV_FINE     = 4'hb;
	localparam logic [3:0] REG_ENV_COARSE   = 4'hc;
	localparam logic [3:0] REG_ENV_SHAPE    = 4'hd;
	localparam logic [3:0] REG_FIRST_PORT   = 4'he;
	localparam logic [3:0] REG_SECOND_PORT  = 4'hf;
	localparam int         EN_NOISE_LSB     = 3;
	localparam int         EN_FIRST_DIR     = 6;
	localparam int         EN_SECOND_DIR    = 7;
	localparam int         AMP_ENV_BIT      = 4;
	localparam int         SHAPE_CONT       = 3;
	localparam int         SHAPE_ATTACK     = 2;
	localparam int         SHAPE_ALT        = 1;
	localparam int         SHAPE_HOLD       = 0;
	localparam logic [7:0] REG_RESET        = 8'h00;

	// ----------------------------------------------------------------
	// Bus codes {direction, first control} with second control high
	// ----------------------------------------------------------------
	localparam logic [1:0] BUS_INACTIVE     = 2'b00;
	localparam logic [1:0] BUS_READ         = 2'b01;
	localparam logic [1:0] BUS_WRITE        = 2'b10;
	localparam logic [1:0] BUS_LATCH        = 2'b11;

	// ----------------------------------------------------------------
	// Chip select defaults and generator timing
	// ----------------------------------------------------------------
	localparam logic       SEL_HIGH_MATCH   = 1'b0;
	localparam logic       SEL_LOW_MATCH    = 1'b1;
	localparam logic [7:0] PRESCALE_TONE    = 8'h0f;
	localparam logic [7:0] PRESCALE_ENV     = 8'hff;
	localparam logic [16:0] NOISE_SEED      = 17'h00001;

	// ----------------------------------------------------------------
	// Host controller APB map
	// ----------------------------------------------------------------
	localparam logic [7:0] HOST_CMD         = 8'h00;
	localparam logic [7:0] HOST_WDATA       = 8'h04;
	localparam logic [7:0] HOST_RDATA       = 8'h08;
	localparam logic [7:0] HOST_STATUS      = 8'h0c;
	localparam logic [7:0] HOST_SELECT      = 8'h10;
	localparam int         CMD_WRITE_BIT    = 8;
	localparam int         SEL_LOW_BIT      = 4;
	localparam int         SEL_HIGH_BIT     = 5;
	localparam logic [5:0] HOST_SELECT_RST  = 6'h10;

endpackage : sgb_pkg
`default_nettype wire

// File: rtl/sgb_if.sv
// Multiplexed bus between the host controller and the sound generator
`default_nettype none
interface sgb_if;

	// ----------------------------------------------------------------
	// Bus wires
	// ----------------------------------------------------------------
	logic       bus_direction_in;
	logic       bus_control_first;
	logic       bus_control_second;
	logic       extra_select_high;
	logic       extra_select_low;
	logic [7:0] host_da;
	logic       host_da_oe_n;
	logic [7:0] dev_da;
	logic       dev_da_oe_n;
	logic [7:0] muxed_data_address_bus;

	// Wire level: driver wins, idle bus floats high
	assign muxed_data_address_bus = !host_da_oe_n ? host_da :
		(!dev_da_oe_n ? dev_da : 8'hff);

	modport host (
		output bus_direction_in, bus_control_first, bus_control_second,
		output extra_select_high, extra_select_low, host_da, host_da_oe_n,
		input  muxed_data_address_bus
	);

	modport device (
		input  bus_direction_in, bus_control_first, bus_control_second,
		input  extra_select_high, extra_select_low, muxed_data_address_bus,
		output dev_da, dev_da_oe_n
	);

endinterface : sgb_if
`default_nettype wire

// File: rtl/sgb_host.sv
// Host controller: APB registers in, multiplexed bus cycles out
`default_nettype none
module sgb_host #(
	parameter int PHASE_CYCLES = 4
) (
	// Clock and reset
	input  wire logic        I_CLOCK,
	input  wire logic        I_RESET_N,
	// APB slave
	input  wire logic        i_PSEL,
	input  wire logic        i_PENABLE,
	input  wire logic        i_PWRITE,
	input  wire logic [7:0]  i_PADDR,
	input  wire logic [31:0] i_PWDATA,
	output logic      [31:0] o_PRDATA,
	output logic             o_PREADY,
	output logic             o_PSLVERR,
	// Sound generator bus
	sgb_if.host              bus
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_LATCH, ST_GAP, ST_DATA, ST_END} sgb_host_e;

	sgb_host_e  state;
	logic [7:0] phase;
	logic [3:0] cmd_reg;
	logic       cmd_write;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [5:0] select;
	logic       setup;
	logic       access;
	logic       mapped;
	logic       phase_done;

	assign setup      = i_PSEL && !i_PENABLE;
	assign access     = i_PSEL && i_PENABLE;
	assign phase_done = (phase == 8'(PHASE_CYCLES - 1));
	assign mapped     = (i_PADDR == sgb_pkg::HOST_CMD) || (i_PADDR == sgb_pkg::HOST_WDATA) ||
		(i_PADDR == sgb_pkg::HOST_RDATA) || (i_PADDR == sgb_pkg::HOST_STATUS) ||
		(i_PADDR == sgb_pkg::HOST_SELECT);

	// Slave answers in the first access cycle
	assign o_PREADY  = 1'b1;
	assign o_PSLVERR = access && !mapped;

	// ----------------------------------------------------------------
	// APB read data, captured in the setup cycle
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			o_PRDATA <= 32'h0;
		end else if (setup) begin
			unique case (i_PADDR)
				sgb_pkg::HOST_CMD:    o_PRDATA <= {23'h0, cmd_write, 4'h0, cmd_reg};
				sgb_pkg::HOST_WDATA:  o_PRDATA <= {24'h0, wdata};
				sgb_pkg::HOST_RDATA:  o_PRDATA <= {24'h0, rdata};
				sgb_pkg::HOST_STATUS: o_PRDATA <= {31'h0, state != ST_IDLE};
				sgb_pkg::HOST_SELECT: o_PRDATA <= {26'h0, select};
				default:              o_PRDATA <= 32'h0;
			endcase
		end
	end

	// Data and select registers
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			wdata  <= 8'h0;
			select <= sgb_pkg::HOST_SELECT_RST;
		end else if (access && i_PWRITE) begin
			if (i_PADDR == sgb_pkg::HOST_WDATA)
				wdata <= i_PWDATA[7:0];
			if (i_PADDR == sgb_pkg::HOST_SELECT)
				select <= i_PWDATA[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Bus sequencer: latch cycle, gap, data cycle, gap
	// ----------------------------------------------------------------
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			state     <= ST_IDLE;
			phase     <= 8'h0;
			cmd_reg   <= 4'h0;
			cmd_write <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					// Command accepted only while idle
					if (access && i_PWRITE && i_PADDR == sgb_pkg::HOST_CMD) begin
						cmd_reg   <= i_PWDATA[3:0];
						cmd_write <= i_PWDATA[sgb_pkg::CMD_WRITE_BIT];
						state     <= ST_LATCH;
						phase     <= 8'h0;
					end
				end
				ST_LATCH, ST_GAP, ST_DATA: begin
					if (phase_done) begin
						phase <= 8'h0;
						state <= (state == ST_LATCH) ? ST_GAP :
							((state == ST_GAP) ? ST_DATA : ST_END);
					end else begin
						phase <= phase + 8'h1;
					end
				end
				ST_END: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Read data taken on the last cycle of a read cycle
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			rdata <= 8'h0;
		end else if (state == ST_DATA && !cmd_write && phase_done) begin
			rdata <= bus.muxed_data_address_bus;
		end
	end

	// ----------------------------------------------------------------
	// Bus pins
	// ----------------------------------------------------------------
	assign bus.bus_control_second = 1'b1;
	assign bus.bus_direction_in   = (state == ST_LATCH) || (state == ST_DATA && cmd_write);
	assign bus.bus_control_first  = (state == ST_LATCH) || (state == ST_DATA && !cmd_write);
	assign bus.extra_select_high  = select[sgb_pkg::SEL_HIGH_BIT];
	assign bus.extra_select_low   = select[sgb_pkg::SEL_LOW_BIT];
	assign bus.host_da            = (state == ST_LATCH) ? {select[3:0], cmd_reg} : wdata;
	assign bus.host_da_oe_n       = !((state == ST_LATCH) || (state == ST_DATA && cmd_write));

endmodule : sgb_host
`default_nettype wire

// File: dv/sgb_bus_checker.sv
// Assertions on the bus joining the host controller and the sound generator
`default_nettype none
module sgb_bus_checker #(
	parameter logic [3:0] SELECT_NIBBLE = 4'h0
) (
	// Clock and reset
	input  wire logic       I_CLOCK,
	input  wire logic       I_RESET_N,
	// Bus wires
	input  wire logic       bus_direction_in,
	input  wire logic       bus_control_first,
	input  wire logic       bus_control_second,
	input  wire logic       extra_select_high,
	input  wire logic       extra_select_low,
	input  wire logic       host_da_oe_n,
	input  wire logic [7:0] dev_da,
	input  wire logic       dev_da_oe_n,
	input  wire logic [7:0] muxed_data_address_bus
);

	// ------------------------------------------------------------
	// Shadow of latched register, select match and contents
	// ------------------------------------------------------------
	logic [1:0] code;
	logic       sel_ok;
	logic [3:0] cur_reg;
	logic [7:0] shadow [16];
	assign code = {bus_direction_in, bus_control_first};

	// Register number and select match taken on latch cycles
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			sel_ok  <= 1'b0;
			cur_reg <= 4'h0;
		end else if (bus_control_second && code == sgb_pkg::BUS_LATCH) begin
			cur_reg <= muxed_data_address_bus[3:0];
			sel_ok  <= muxed_data_address_bus[7:4] == SELECT_NIBBLE &&
				extra_select_high == sgb_pkg::SEL_HIGH_MATCH &&
				extra_select_low == sgb_pkg::SEL_LOW_MATCH;
		end
	end

	// Expected contents follow selected write cycles only
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			for (int i = 0; i < 16; i++) begin
				shadow[i] <= 8'h00;
			end
		end else if (code == sgb_pkg::BUS_WRITE && sel_ok) begin
			shadow[cur_reg] <= muxed_data_address_bus;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RESET_N);

	property p_second_high;
		bus_control_second;
	endproperty
	a_second_high: assert property (p_second_high) else $error("second control low");
	property p_drive_on_read;
		!dev_da_oe_n |-> code == sgb_pkg::BUS_READ;
	endproperty
	a_drive_on_read: assert property (p_drive_on_read) else $error("device drives off read");
	property p_drive_needs_sel;
		!dev_da_oe_n |-> sel_ok;
	endproperty
	a_drive_needs_sel: assert property (p_drive_needs_sel) else $error("drive unselected");
	property p_sel_read_drives;
		code == sgb_pkg::BUS_READ && sel_ok |-> !dev_da_oe_n;
	endproperty
	a_sel_read_drives: assert property (p_sel_read_drives) else $error("read not driven");
	property p_read_data;
		code == sgb_pkg::BUS_READ && $past(code) == sgb_pkg::BUS_READ && sel_ok &&
			cur_reg < 4'he |-> dev_da == shadow[cur_reg];
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data differs");
	property p_latch_host_drives;
		code == sgb_pkg::BUS_LATCH |-> !host_da_oe_n;
	endproperty
	a_latch_host_drives: assert property (p_latch_host_drives) else $error("latch undriven");
	property p_host_quiet_read;
		code == sgb_pkg::BUS_READ |-> host_da_oe_n;
	endproperty
	a_host_quiet_read: assert property (p_host_quiet_read) else $error("host drives on read");
	property p_gap_before_data;
		(code[1] ^ code[0]) && !$past(code[1] ^ code[0]) |-> $past(code) == sgb_pkg::BUS_INACTIVE;
	endproperty
	a_gap_before_data: assert property (p_gap_before_data) else $error("data without gap");
	property p_latch_held;
		$rose(code == sgb_pkg::BUS_LATCH) |-> (code == sgb_pkg::BUS_LATCH) [*2];
	endproperty
	a_latch_held: assert property (p_latch_held) else $error("latch too short");
	property p_reset_idle;
		$rose(I_RESET_N) |-> dev_da_oe_n && host_da_oe_n && code == sgb_pkg::BUS_INACTIVE;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("bus busy after reset");

endmodule : sgb_bus_checker
`default_nettype wire

// File: dv/tb_sound_generator_bus_port.sv
// Bench: host controller and sound generator joined by the shared bus
`default_nettype none
module tb_sound_generator_bus_port;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	localparam logic [3:0] SEL_NIB = 4'h0;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        pready, pslverr, e;
	logic [7:0]  paddr = 8'h00, p1_in = 8'h00, p1_drv = 8'h00, p2_in = 8'h00, p2_drv = 8'h00;
	logic [7:0]  p1_out, p1_oe_n, p2_out, p2_oe_n;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [3:0]  lvl_a, lvl_b, lvl_c;
	logic [7:0]  bad_sel [3] = '{8'h11, 8'h00, 8'h30};
	int          failures = 0, num_checks = 0, cycles = 0;

	sgb_if sgb_if_inst ();
	sgb_host sgb_host_inst (.I_CLOCK(clk), .I_RESET_N(rst_n), .i_PSEL(psel),
		.i_PENABLE(penable), .i_PWRITE(pwrite), .i_PADDR(paddr), .i_PWDATA(pwdata),
		.o_PRDATA(prdata), .o_PREADY(pready), .o_PSLVERR(pslverr), .bus(sgb_if_inst.host));
	sgb_device #(.SELECT_NIBBLE(SEL_NIB)) sgb_device_inst (.I_CLOCK(clk), .I_RESET_N(rst_n),
		.bus(sgb_if_inst.device), .i_FIRST_PORT_IN(p1_in), .i_FIRST_PORT_DRIVEN(p1_drv),
		.o_FIRST_PORT_OUT(p1_out), .o_FIRST_PORT_OE_N(p1_oe_n), .i_SECOND_PORT_IN(p2_in),
		.i_SECOND_PORT_DRIVEN(p2_drv), .o_SECOND_PORT_OUT(p2_out), .o_SECOND_PORT_OE_N(p2_oe_n),
		.o_LEVEL_A(lvl_a), .o_LEVEL_B(lvl_b), .o_LEVEL_C(lvl_c));
	sgb_bus_checker #(.SELECT_NIBBLE(SEL_NIB)) sgb_bus_checker_inst (.I_CLOCK(clk),
		.I_RESET_N(rst_n), .bus_direction_in(sgb_if_inst.bus_direction_in),
		.bus_control_first(sgb_if_inst.bus_control_first),
		.bus_control_second(sgb_if_inst.bus_control_second),
		.extra_select_high(sgb_if_inst.extra_select_high),
		.extra_select_low(sgb_if_inst.extra_select_low), .host_da_oe_n(sgb_if_inst.host_da_oe_n),
		.dev_da(sgb_if_inst.dev_da), .dev_da_oe_n(sgb_if_inst.dev_da_oe_n),
		.muxed_data_address_bus(sgb_if_inst.muxed_data_address_bus));

	// ------------------------------------------------------------
	// Clock, hang guard and tasks
	// ------------------------------------------------------------
	initial begin
		forever #20 clk = ~clk;
	end

	// Cut a hang short well past the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			failures++;
			finish_test();
		end
	end

	// Compare a seen value against the expected one
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// One APB transfer, held until the slave answers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	// Device register access through the host command registers
	task automatic dev(input logic w, input logic [3:0] r, input logic [7:0] d,
		output logic [31:0] v);
		logic [31:0] s;
		logic        x;
		apb(1'b1, sgb_pkg::HOST_WDATA, {24'h0, d}, s, x);
		apb(1'b1, sgb_pkg::HOST_CMD, {23'h0, w, 4'h0, r}, s, x);
		s = 32'h1;
		for (int i = 0; i < 50 && s[0] !== 1'b0; i++) begin
			apb(1'b0, sgb_pkg::HOST_STATUS, 32'h0, s, x);
		end
		if (s[0] !== 1'b0) failures++;
		apb(1'b0, sgb_pkg::HOST_RDATA, 32'h0, s, x);
		v = {24'h0, s[7:0]};
	endtask : dev

	// Verdict and end of run
	task automatic finish_test();
		if (failures == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// Reset state
		apb(1'b0, sgb_pkg::HOST_SELECT, 32'h0, q, e);
		check("select reset", q, {26'h0, sgb_pkg::HOST_SELECT_RST});
		check("port dirs", {24'h0, p1_oe_n & p2_oe_n}, 32'hff);
		for (int r = 0; r < 16; r++) begin
			dev(1'b0, 4'(r), 8'h00, q);
			check("reset reg", q, r < 14 ? 32'h0 : 32'hff);
		end
		// Distinct pattern into every sound register, then read all back
		for (int r = 0; r < 14; r++) begin
			dev(1'b1, 4'(r), {4'(r), ~4'(r)}, q);
		end
		for (int r = 0; r < 14; r++) begin
			dev(1'b0, 4'(r), 8'h00, q);
			check("readback", q, {24'h0, 4'(r), ~4'(r)});
		end
		// Foreign select: write ignored, bus left floating
		foreach (bad_sel[i]) begin
			apb(1'b1, sgb_pkg::HOST_SELECT, {24'h0, bad_sel[i]}, q, e);
			dev(1'b1, 4'h0, 8'hee, q);
			dev(1'b0, 4'h0, 8'h00, q);
			check("foreign read", q, 32'hff);
			apb(1'b1, sgb_pkg::HOST_SELECT, 32'h10, q, e);
			dev(1'b0, 4'h0, 8'h00, q);
			check("kept reg", q, 32'h0f);
		end
		// Both ports out, then first port back to input and out again
		dev(1'b1, sgb_pkg::REG_ENABLE, 8'hc0, q);
		dev(1'b1, sgb_pkg::REG_FIRST_PORT, 8'h5a, q);
		dev(1'b1, sgb_pkg::REG_SECOND_PORT, 8'h3c, q);
		check("ports out", {8'h0, p1_out, p2_out, p1_oe_n | p2_oe_n}, 32'h5a3c00);
		dev(1'b0, sgb_pkg::REG_FIRST_PORT, 8'h00, q);
		check("first latch", q, 32'h5a);
		p1_in  <= 8'h96;
		p1_drv <= 8'h0f;
		dev(1'b1, sgb_pkg::REG_ENABLE, 8'h80, q);
		check("first dir in", {24'h0, p1_oe_n}, 32'hff);
		dev(1'b0, sgb_pkg::REG_FIRST_PORT, 8'h00, q);
		check("first pins", q, 32'hf6);
		dev(1'b1, sgb_pkg::REG_ENABLE, 8'hc0, q);
		check("latch cleared", {16'h0, p1_out, p2_out}, 32'h003c);
		// System wiring: second port out with select, joystick on first port
		dev(1'b1, sgb_pkg::REG_ENABLE, 8'h80, q);
		dev(1'b1, sgb_pkg::REG_SECOND_PORT, 8'h4f, q);
		p1_in  <= 8'hb5;
		p1_drv <= 8'hbf;
		dev(1'b0, sgb_pkg::REG_FIRST_PORT, 8'h00, q);
		check("joystick", {16'h0, q[7:0], p2_out}, 32'hf54f);
		// Fixed level on A, rising envelope held at top on B, silence on C
		dev(1'b1, sgb_pkg::REG_ENABLE, 8'h3f, q);
		dev(1'b1, sgb_pkg::REG_AMP_A, 8'h0b, q);
		dev(1'b1, sgb_pkg::REG_AMP_A + 4'h1, 8'h10, q);
		dev(1'b1, sgb_pkg::REG_AMP_A + 4'h2, 8'h00, q);
		dev(1'b1, sgb_pkg::REG_ENV_FINE, 8'h01, q);
		dev(1'b1, sgb_pkg::REG_ENV_COARSE, 8'h00, q);
		dev(1'b1, sgb_pkg::REG_ENV_SHAPE, 8'h0d, q);
		repeat (10000) @(posedge clk);
		check("levels", {20'h0, lvl_a, lvl_b, lvl_c}, 32'hbf0);
		// Tone A alone at the shortest period must square-wave channel A
		dev(1'b1, 4'h0, 8'h01, q);
		dev(1'b1, 4'h1, 8'h00, q);
		dev(1'b1, sgb_pkg::REG_ENABLE, 8'h3e, q);
		q = 32'h0;
		repeat (40) begin
			@(posedge clk);
			q[0] = q[0] | (lvl_a == 4'h0);
			q[1] = q[1] | (lvl_a == 4'hb);
		end
		check("tone A", q, 32'h3);
		// Unmapped host address
		apb(1'b0, 8'h20, 32'h0, q, e);
		check("unmapped", {q[30:0], e}, 32'h1);
		// Reset in mid-run clears the device
		dev(1'b1, 4'h3, 8'h99, q);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		dev(1'b0, 4'h3, 8'h00, q);
		check("after reset", {q[15:0], p1_oe_n, p2_oe_n}, 32'hffff);
		finish_test();
	end

endmodule : tb_sound_generator_bus_port
`default_nettype wire
